// file: verilog/pocpc_defs.vh
// Constants of the pulse output configuration and phase compensation block.
// Assumes inclusion by bare name from the design file of the same block.
`ifndef POCPC_DEFS_VH
`define POCPC_DEFS_VH

// Register offsets on the host register port
`define POCPC_OFS_PULSE_CFG      16'hE610
`define POCPC_OFS_PHASE_A_COMP   16'hE614
`define POCPC_OFS_PHASE_B_COMP   16'hE615
`define POCPC_OFS_PHASE_C_COMP   16'hE616

// Field positions in the pulse output configuration register
`define POCPC_SEL1_LSB           0
`define POCPC_SEL2_LSB           3
`define POCPC_SEL3_LSB           6
`define POCPC_SEL_W              3
`define POCPC_GATE_LSB           9
`define POCPC_CAPT_LSB           12
`define POCPC_CFG_USED_W         15

// Field positions in each phase compensation register
`define POCPC_COMP_W             10

// Reset values
`define POCPC_RST_PULSE_CFG      16'h0E88
`define POCPC_RST_PHASE_COMP     16'h0000
`define POCPC_RST_READ           16'h0000

// Power quantity codes of each source field
`define POCPC_SRC_TOTAL_ACT      3'h0
`define POCPC_SRC_TOTAL_REACT    3'h1
`define POCPC_SRC_APPARENT       3'h2
`define POCPC_SRC_FUND_ACT       3'h3
`define POCPC_SRC_FUND_REACT     3'h4
`define POCPC_SRC_LAST           3'h4

// Phase compensation alias bounds
`define POCPC_COMP_ALIAS1_LO     10'h180
`define POCPC_COMP_ALIAS2_LO     10'h200
`define POCPC_COMP_ALIAS1_BASE   10'h100
`define POCPC_COMP_ALIAS2_BASE   10'h180

`endif

// file: verilog/pocpc_regs.v
// Pulse output configuration and per-phase compensation register bank.
// Assumes a host register port synchronous to mclk_i, per-phase power words
// from the metering datapath and pulse strobes from the frequency converters.
//
// Summary of operation
// - Output one source code picks total/fund active, reactive or apparent power sum.
// - Output two source uses same codes, resets to total reactive.
// - Output three source uses same codes, resets to apparent power.
// - Reserved source codes 101, 110, 111 act as total active power.
// - Gate bits 9 to 11, reset set, block their pulse pin while set.
// - Converter keeps running while gated; only the pin is suppressed.
// - Capture bits 12 to 14 latch energy registers on each converter pulse, gated or not.
// - Compensation codes 384 to 511 act like 256 to 383.
// - Compensation codes 512 to 1023 act like 384 to 511.
// - Top configuration bit and upper six compensation bits do nothing.
// - Phase include bits add phases A, B, C into each output sum.
`timescale 1ns/1ps
`default_nettype none
`include "pocpc_defs.vh"

module pocpc_regs #(
   parameter PW = 24
) (
   input  wire              mclk_i,
   input  wire              rst_n_i,
   // Host register port
   input  wire [15:0]       reg_addr_i,
   input  wire [15:0]       reg_wdata_i,
   input  wire              reg_wr_i,
   input  wire              reg_rd_i,
   output reg  [15:0]       reg_rdata_o,
   // Phase include bits of the computation mode register
   input  wire [2:0]        pulse1_phase_include_i,
   input  wire [2:0]        pulse2_phase_include_i,
   input  wire [2:0]        pulse3_phase_include_i,
   // Per-phase powers, phase A in the low slice
   input  wire [3*PW-1:0]   total_active_i,
   input  wire [3*PW-1:0]   total_reactive_i,
   input  wire [3*PW-1:0]   apparent_i,
   input  wire [3*PW-1:0]   fund_active_i,
   input  wire [3*PW-1:0]   fund_reactive_i,
   // Pulse strobes from the three frequency converters
   input  wire [2:0]        dfc_pulse_i,
   // Power sums to the frequency converters
   output reg  [PW+1:0]     pulse1_power_sum_o,
   output reg  [PW+1:0]     pulse2_power_sum_o,
   output reg  [PW+1:0]     pulse3_power_sum_o,
   // Effective source codes in use
   output reg  [2:0]        pulse1_source_eff_o,
   output reg  [2:0]        pulse2_source_eff_o,
   output reg  [2:0]        pulse3_source_eff_o,
   // Pulse output pins
   output reg               pulse_output_one_o,
   output reg               pulse_output_two_o,
   output reg               pulse_output_three_o,
   // Energy register capture strobes
   output reg  [2:0]        energy_capture_o,
   // Effective phase compensation codes
   output reg  [9:0]        phase_a_comp_eff_o,
   output reg  [9:0]        phase_b_comp_eff_o,
   output reg  [9:0]        phase_c_comp_eff_o
);

   localparam SW = `POCPC_SEL_W;
   localparam CW = `POCPC_COMP_W;
   // Full-width reset words; only their used bits are stored
   localparam [15:0] CFG_RST  = `POCPC_RST_PULSE_CFG;
   localparam [15:0] COMP_RST = `POCPC_RST_PHASE_COMP;

   // Stored register contents, used bits only
   reg [`POCPC_CFG_USED_W-1:0] pulse_output_config_reg;
   reg [`POCPC_CFG_USED_W-1:0] pulse_output_config_next;
   reg [CW-1:0]                phase_a_phase_compensation_reg;
   reg [CW-1:0]                phase_a_phase_compensation_next;
   reg [CW-1:0]                phase_b_phase_compensation_reg;
   reg [CW-1:0]                phase_b_phase_compensation_next;
   reg [CW-1:0]                phase_c_phase_compensation_reg;
   reg [CW-1:0]                phase_c_phase_compensation_next;
   reg [15:0]                  read_next;

   // Field views of the configuration register
   wire [SW-1:0] pulse1_source_select;
   wire [SW-1:0] pulse2_source_select;
   wire [SW-1:0] pulse3_source_select;
   wire          pulse1_pin_gate;
   wire          pulse2_pin_gate;
   wire          pulse3_pin_gate;
   wire          pulse1_energy_capture;
   wire          pulse2_energy_capture;
   wire          pulse3_energy_capture;
   wire [15*PW-1:0] all_powers;

   assign pulse1_source_select  = pulse_output_config_reg[`POCPC_SEL1_LSB +: SW];
   assign pulse2_source_select  = pulse_output_config_reg[`POCPC_SEL2_LSB +: SW];
   assign pulse3_source_select  = pulse_output_config_reg[`POCPC_SEL3_LSB +: SW];
   assign pulse1_pin_gate       = pulse_output_config_reg[`POCPC_GATE_LSB];
   assign pulse2_pin_gate       = pulse_output_config_reg[`POCPC_GATE_LSB + 1];
   assign pulse3_pin_gate       = pulse_output_config_reg[`POCPC_GATE_LSB + 2];
   assign pulse1_energy_capture = pulse_output_config_reg[`POCPC_CAPT_LSB];
   assign pulse2_energy_capture = pulse_output_config_reg[`POCPC_CAPT_LSB + 1];
   assign pulse3_energy_capture = pulse_output_config_reg[`POCPC_CAPT_LSB + 2];

   // Quantities packed in source code order
   assign all_powers = {fund_reactive_i, fund_active_i, apparent_i,
                        total_reactive_i, total_active_i};

   // Reserved source codes fall back to total active power
   function [2:0] source_eff;
      input [2:0] code;
      begin
         if (code > `POCPC_SRC_LAST) begin
            source_eff = `POCPC_SRC_TOTAL_ACT;
         end else begin
            source_eff = code;
         end
      end
   endfunction

   // Signed sum of the chosen quantity over the included phases
   function [PW+1:0] power_sum;
      input [2:0]       code;
      input [2:0]       incl;
      input [15*PW-1:0] powers;
      reg   [PW-1:0]    term;
      reg   [PW+1:0]    acc;
      integer           p;
      begin
         term = {PW{1'b0}};
         acc  = {(PW+2){1'b0}};
         for (p = 0; p < 3; p = p + 1) begin
            term = powers[(source_eff(code) * 3 + p) * PW +: PW];
            if (incl[p]) begin
               acc = acc + {{2{term[PW-1]}}, term};
            end
         end
         power_sum = acc;
      end
   endfunction

   // Compensation code folded into its effective range
   function [9:0] comp_eff;
      input [9:0] code;
      begin
         if (code >= `POCPC_COMP_ALIAS2_LO) begin
            comp_eff = `POCPC_COMP_ALIAS2_BASE | {3'h0, code[6:0]};
         end else if (code >= `POCPC_COMP_ALIAS1_LO) begin
            comp_eff = `POCPC_COMP_ALIAS1_BASE | {3'h0, code[6:0]};
         end else begin
            comp_eff = code;
         end
      end
   endfunction

   // Register write decode; unused upper bits are dropped
   always @* begin
      pulse_output_config_next        = pulse_output_config_reg;
      phase_a_phase_compensation_next = phase_a_phase_compensation_reg;
      phase_b_phase_compensation_next = phase_b_phase_compensation_reg;
      phase_c_phase_compensation_next = phase_c_phase_compensation_reg;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `POCPC_OFS_PULSE_CFG: begin
               pulse_output_config_next = reg_wdata_i[`POCPC_CFG_USED_W-1:0];
            end
            `POCPC_OFS_PHASE_A_COMP: begin
               phase_a_phase_compensation_next = reg_wdata_i[CW-1:0];
            end
            `POCPC_OFS_PHASE_B_COMP: begin
               phase_b_phase_compensation_next = reg_wdata_i[CW-1:0];
            end
            `POCPC_OFS_PHASE_C_COMP: begin
               phase_c_phase_compensation_next = reg_wdata_i[CW-1:0];
            end
            default: begin
               pulse_output_config_next = pulse_output_config_reg;
            end
         endcase
      end
   end

   // Read mux; raw codes come back, reserved bits as zero
   always @* begin
      read_next = `POCPC_RST_READ;
      case (reg_addr_i)
         `POCPC_OFS_PULSE_CFG: begin
            read_next = {1'b0, pulse_output_config_reg};
         end
         `POCPC_OFS_PHASE_A_COMP: begin
            read_next = {6'h00, phase_a_phase_compensation_reg};
         end
         `POCPC_OFS_PHASE_B_COMP: begin
            read_next = {6'h00, phase_b_phase_compensation_reg};
         end
         `POCPC_OFS_PHASE_C_COMP: begin
            read_next = {6'h00, phase_c_phase_compensation_reg};
         end
         default: begin
            read_next = `POCPC_RST_READ;
         end
      endcase
   end

   // Configuration word with its documented default
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_output_config_reg <= CFG_RST[`POCPC_CFG_USED_W-1:0];
      end else begin
         pulse_output_config_reg <= pulse_output_config_next;
      end
   end

   // Phase A compensation word, cleared on reset
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_a_phase_compensation_reg <= COMP_RST[CW-1:0];
      end else begin
         phase_a_phase_compensation_reg <= phase_a_phase_compensation_next;
      end
   end

   // Phase B compensation word, cleared on reset
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_b_phase_compensation_reg <= COMP_RST[CW-1:0];
      end else begin
         phase_b_phase_compensation_reg <= phase_b_phase_compensation_next;
      end
   end

   // Phase C compensation word, cleared on reset
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_c_phase_compensation_reg <= COMP_RST[CW-1:0];
      end else begin
         phase_c_phase_compensation_reg <= phase_c_phase_compensation_next;
      end
   end

   // Read data, valid only in the cycle after the strobe
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= `POCPC_RST_READ;
      end else if (reg_rd_i) begin
         reg_rdata_o <= read_next;
      end else begin
         reg_rdata_o <= `POCPC_RST_READ;
      end
   end

   // Output one sum feeds its converter whatever the gate bit says
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse1_power_sum_o  <= {(PW+2){1'b0}};
         pulse1_source_eff_o <= `POCPC_SRC_TOTAL_ACT;
      end else begin
         pulse1_power_sum_o  <= power_sum(pulse1_source_select,
                                          pulse1_phase_include_i, all_powers);
         pulse1_source_eff_o <= source_eff(pulse1_source_select);
      end
   end

   // Output two sum, reset source is total reactive
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse2_power_sum_o  <= {(PW+2){1'b0}};
         pulse2_source_eff_o <= `POCPC_SRC_TOTAL_REACT;
      end else begin
         pulse2_power_sum_o  <= power_sum(pulse2_source_select,
                                          pulse2_phase_include_i, all_powers);
         pulse2_source_eff_o <= source_eff(pulse2_source_select);
      end
   end

   // Output three sum, reset source is apparent power
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse3_power_sum_o  <= {(PW+2){1'b0}};
         pulse3_source_eff_o <= `POCPC_SRC_APPARENT;
      end else begin
         pulse3_power_sum_o  <= power_sum(pulse3_source_select,
                                          pulse3_phase_include_i, all_powers);
         pulse3_source_eff_o <= source_eff(pulse3_source_select);
      end
   end

   // Output one pin; a set gate bit holds it low
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_output_one_o <= 1'b0;
      end else begin
         pulse_output_one_o <= dfc_pulse_i[0] & ~pulse1_pin_gate;
      end
   end

   // Output two pin; converter strobes still arrive while gated
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_output_two_o <= 1'b0;
      end else begin
         pulse_output_two_o <= dfc_pulse_i[1] & ~pulse2_pin_gate;
      end
   end

   // Output three pin; only the pin is suppressed
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_output_three_o <= 1'b0;
      end else begin
         pulse_output_three_o <= dfc_pulse_i[2] & ~pulse3_pin_gate;
      end
   end

   // Energy capture on each converter pulse, independent of gating
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         energy_capture_o <= 3'h0;
      end else begin
         energy_capture_o <= dfc_pulse_i & {pulse3_energy_capture,
                                            pulse2_energy_capture,
                                            pulse1_energy_capture};
      end
   end

   // Phase A effective code; out-of-range codes fold down
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_a_comp_eff_o <= 10'h000;
      end else begin
         phase_a_comp_eff_o <= comp_eff(phase_a_phase_compensation_reg);
      end
   end

   // Phase B effective code; out-of-range codes fold down
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_b_comp_eff_o <= 10'h000;
      end else begin
         phase_b_comp_eff_o <= comp_eff(phase_b_phase_compensation_reg);
      end
   end

   // Phase C effective code; out-of-range codes fold down
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_c_comp_eff_o <= 10'h000;
      end else begin
         phase_c_comp_eff_o <= comp_eff(phase_c_phase_compensation_reg);
      end
   end

endmodule // pocpc_regs

`default_nettype wire

// file: tb/pocpc_regs_assertions.sv
// Checker of the pulse configuration and phase compensation bank.
// Assumes a bind onto pocpc_regs; it sees that module's ports only.
`timescale 1ns/1ps
`default_nettype none
`include "pocpc_defs.vh"
module pocpc_regs_assertions #(parameter PW = 24) (
   input wire        mclk_i,
   input wire        rst_n_i,
   input wire [15:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire [2:0]  dfc_pulse_i,
   input wire [2:0]  pulse1_source_eff_o,
   input wire        pulse_output_one_o,
   input wire        pulse_output_two_o,
   input wire        pulse_output_three_o,
   input wire [2:0]  energy_capture_o,
   input wire [9:0]  phase_a_comp_eff_o
);
   // Writes to the configuration and phase A words
   wire cfg_wr = reg_wr_i && (reg_addr_i == `POCPC_OFS_PULSE_CFG);
   wire pa_wr  = reg_wr_i && (reg_addr_i == `POCPC_OFS_PHASE_A_COMP);
   // Last written configuration word, for gate and capture checks
   localparam [15:0] CFG_RST = `POCPC_RST_PULSE_CFG;
   reg [14:0] cfg_shadow;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) cfg_shadow <= CFG_RST[14:0];
      else if (cfg_wr) cfg_shadow <= reg_wdata_i[14:0];
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   a_pin_needs_pulse: assert property (
      ({pulse_output_three_o, pulse_output_two_o, pulse_output_one_o} & ~$past(dfc_pulse_i))
      == 3'h0) else $error("pin high without converter pulse");
   a_capture_needs_pulse: assert property (
      (energy_capture_o & ~$past(dfc_pulse_i)) == 3'h0) else $error("capture without pulse");
   a_rdata_idle_zero: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside slot");
   a_reserved_is_total: assert property (
      cfg_wr && reg_wdata_i[2:0] > 3'h4 |-> ##3 pulse1_source_eff_o == 3'h0)
      else $error("reserved source code not total active");
   a_comp_alias_high: assert property (
      pa_wr && reg_wdata_i[9] |-> ##3 phase_a_comp_eff_o == {3'b011, $past(reg_wdata_i[6:0], 3)})
      else $error("upper compensation alias wrong");
   a_comp_alias_mid: assert property (
      pa_wr && reg_wdata_i[9:7] == 3'b011
      |-> ##3 phase_a_comp_eff_o == {3'b010, $past(reg_wdata_i[6:0], 3)})
      else $error("middle compensation alias wrong");
   a_gate_blocks_pin: assert property (
      cfg_shadow[9] && dfc_pulse_i[0] |=> !pulse_output_one_o) else $error("gated pin pulsed");
   a_gate_opens_pin: assert property (
      !cfg_shadow[9] && dfc_pulse_i[0] |=> pulse_output_one_o)
      else $error("open pin missed pulse");
   a_capture_while_gated: assert property (
      cfg_shadow[12] && cfg_shadow[9] && dfc_pulse_i[0] |=> energy_capture_o[0])
      else $error("capture missed pulse");
endmodule // pocpc_regs_assertions
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the pulse configuration and phase compensation bank.
// Assumes pocpc_regs built with PW of 8 and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
`include "pocpc_defs.vh"
module tb;
   localparam PW = 8;
   localparam CFG = `POCPC_OFS_PULSE_CFG;
   reg              mclk_i = 1'b0;
   reg              rst_n_i = 1'b0;
   reg  [15:0]      reg_addr_i = 16'h0000;
   reg  [15:0]      reg_wdata_i = 16'h0000;
   reg              reg_wr_i = 1'b0;
   reg              reg_rd_i = 1'b0;
   reg  [8:0]       incl = 9'h1FF;
   reg  [2:0]       dfc = 3'h0;
   reg  [3*PW-1:0]  pw [0:4];
   reg  [14:0]      row [0:7];
   wire [15:0]      rdata;
   wire [PW+1:0]    sum [0:2];
   wire [2:0]       eff [0:2];
   wire [2:0]       pin;
   wire [2:0]       capt;
   wire [9:0]       comp [0:2];
   integer          failures = 0;
   integer          comparisons = 0;
   integer          i, p;
   // Clock of 5 ns
   initial forever #2.5 mclk_i = ~mclk_i;
   pocpc_regs #(.PW(PW)) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(rdata), .pulse1_phase_include_i(incl[2:0]),
      .pulse2_phase_include_i(incl[5:3]), .pulse3_phase_include_i(incl[8:6]),
      .total_active_i(pw[0]), .total_reactive_i(pw[1]), .apparent_i(pw[2]),
      .fund_active_i(pw[3]), .fund_reactive_i(pw[4]), .dfc_pulse_i(dfc),
      .pulse1_power_sum_o(sum[0]), .pulse2_power_sum_o(sum[1]), .pulse3_power_sum_o(sum[2]),
      .pulse1_source_eff_o(eff[0]), .pulse2_source_eff_o(eff[1]),
      .pulse3_source_eff_o(eff[2]), .pulse_output_one_o(pin[0]),
      .pulse_output_two_o(pin[1]), .pulse_output_three_o(pin[2]), .energy_capture_o(capt),
      .phase_a_comp_eff_o(comp[0]), .phase_b_comp_eff_o(comp[1]), .phase_c_comp_eff_o(comp[2]));
   // Expected signed sum of one quantity over the chosen phases
   function [15:0] esum(input integer q, input [2:0] m);
      integer k, s;
      begin
         s = 0;
         for (k = 0; k < 3; k = k + 1)
            if (m[k]) s = s + $signed(pw[q][k*PW +: PW]);
         esum = s[PW+1:0];
      end
   endfunction
   task chk(input string n, input [15:0] e, input [15:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task wr(input [15:0] a, input [15:0] d);
      begin
         @(posedge mclk_i);
         reg_wr_i <= 1'b1;
         reg_addr_i <= a;
         reg_wdata_i <= d;
         @(posedge mclk_i);
         reg_wr_i <= 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [15:0] e);
      begin
         @(posedge mclk_i);
         reg_rd_i <= 1'b1;
         reg_addr_i <= a;
         @(posedge mclk_i);
         reg_rd_i <= 1'b0;
         #1 chk("read data", e, rdata);
      end
   endtask
   task settle;
      begin
         repeat (3) @(posedge mclk_i);
         #1;
      end
   endtask
   // Writes three compensation words, then checks readback and effective codes
   task cset(input [47:0] d, input [29:0] e);
      integer k;
      begin
         for (k = 0; k < 3; k = k + 1) wr(16'hE614 + k, d[k*16 +: 16]);
         settle;
         for (k = 0; k < 3; k = k + 1) begin
            rd(16'hE614 + k, {6'h00, d[k*16 +: 10]});
            chk("comp effective", e[k*10 +: 10], comp[k]);
         end
      end
   endtask
   // One converter strobe, then the pins and capture strobes one cycle on
   task pulse(input [2:0] d, input [2:0] ep, input [2:0] ec);
      begin
         @(posedge mclk_i);
         dfc <= d;
         @(posedge mclk_i);
         dfc <= 3'h0;
         #1 chk("pins", ep, pin);
         chk("capture", ec, capt);
      end
   endtask
   task end_sim;
      begin
         $display("comparisons %0d failures %0d", comparisons, failures);
         if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      for (i = 0; i < 15; i = i + 1) pw[i/3][(i%3)*PW +: PW] = i * 7 + 1 - ((i % 3) == 2 ? 40 : 0);
      // Rows: phase include bits, written code, effective code
      row[0] = {9'o777, 3'd0, 3'd0}; row[1] = {9'o124, 3'd1, 3'd1};
      row[2] = {9'o356, 3'd2, 3'd2}; row[3] = {9'o000, 3'd3, 3'd3};
      row[4] = {9'o765, 3'd4, 3'd4}; row[5] = {9'o777, 3'd5, 3'd0};
      row[6] = {9'o531, 3'd6, 3'd0}; row[7] = {9'o642, 3'd7, 3'd0};
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(CFG, 16'h0E88);
      for (i = 0; i < 3; i = i + 1) rd(16'hE614 + i, 16'h0000);
      for (i = 0; i < 3; i = i + 1) chk("source reset", i, eff[i]);
      $display("test reset values done");
      for (i = 0; i < 8; i = i + 1) begin
         incl <= row[i][14:6];
         wr(CFG, {7'h00, {3{row[i][5:3]}}});
         settle;
         rd(CFG, {7'h00, {3{row[i][5:3]}}});
         for (p = 0; p < 3; p = p + 1) begin
            chk("source", row[i][2:0], eff[p]);
            chk("sum", esum(row[i][2:0], row[i][p*3+6 +: 3]), sum[p]);
         end
      end
      $display("test source rows done");
      wr(CFG, 16'hFFFF);
      rd(CFG, 16'h7FFF);
      wr(16'hE611, 16'hFFFF);
      rd(16'hE611, 16'h0000);
      rd(CFG, 16'h7FFF);
      cset({16'h017F, 16'h01A5, 16'hFFFF}, {10'h17F, 10'h125, 10'h1FF});
      cset({16'h023F, 16'h0200, 16'h0180}, {10'h1BF, 10'h180, 10'h100});
      $display("test compensation done");
      wr(CFG, 16'h1E88);
      settle;
      pulse(3'h7, 3'h0, 3'h1);
      wr(CFG, 16'h6C88);
      settle;
      pulse(3'h7, 3'h1, 3'h6);
      wr(CFG, 16'h0088);
      settle;
      pulse(3'h5, 3'h5, 3'h0);
      $display("test gate and capture done");
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(CFG, 16'h0E88);
      chk("comp after reset", 16'h0000, comp[0]);
      $display("test second reset done");
      end_sim;
   end
endmodule // tb
bind pocpc_regs pocpc_regs_assertions #(.PW(PW)) u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .dfc_pulse_i(dfc_pulse_i), .pulse1_source_eff_o(pulse1_source_eff_o),
   .pulse_output_one_o(pulse_output_one_o), .pulse_output_two_o(pulse_output_two_o),
   .pulse_output_three_o(pulse_output_three_o), .energy_capture_o(energy_capture_o),
   .phase_a_comp_eff_o(phase_a_comp_eff_o));
`default_nettype wire
